/* File: src/tre_encoder.sv */
`timescale 1ns/1ps
`default_nettype none
module tre_encoder #(
    parameter bit          DATA_TRIGGER = 1'b0,
    parameter logic [17:0] BONDED       = tre_pkg::BONDED_ALL,
    parameter int          OSC_DIV      = tre_pkg::OSC_DIV,
    parameter int          PILOT_CYC    = tre_pkg::PILOT_CYC,
    parameter int          SYNC_CYC     = tre_pkg::SYNC_CYC,
    parameter int          BIT_CYC      = tre_pkg::BIT_CYC,
    parameter int          SEP_CYC      = tre_pkg::SEP_CYC,
    parameter logic [15:0] HIGH_PAT     = tre_pkg::HIGH_PAT,
    parameter logic [15:0] LOW_PAT      = tre_pkg::LOW_PAT,
    parameter logic [15:0] OPEN_PAT     = tre_pkg::OPEN_PAT
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // trinary address and address/data pads, one per position
    input  wire logic [17:0] addr_or_data_inputs_level,
    input  wire logic [17:0] addr_or_data_inputs_open,
    // dedicated enable, used when DATA_TRIGGER is 0
    input  wire logic        send_trigger,
    // pulled-low data pads for positions 12 to 17
    input  wire logic [5:0]  data_trigger_inputs,
    // serial output and indicators
    output logic             dout,
    output logic             led_n,
    output logic             osc_run
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    localparam logic [15:0] PAT_MASK  = 16'((32'h1 << BIT_CYC) - 32'h1);
    localparam logic [5:0]  DT_BONDED = BONDED[tre_pkg::DT_BASE +: tre_pkg::NUM_DT];

    initial begin
        if (OSC_DIV < 1 || OSC_DIV > (1 << tre_pkg::TICK_W)) begin
            $error("tre_encoder: OSC_DIV out of range");
        end
        if (PILOT_CYC < 1 || PILOT_CYC > (1 << tre_pkg::CNT_W)) begin
            $error("tre_encoder: PILOT_CYC out of range");
        end
        if (SYNC_CYC < 1 || SYNC_CYC > (1 << tre_pkg::CNT_W)) begin
            $error("tre_encoder: SYNC_CYC out of range");
        end
        if (SEP_CYC < 1 || SEP_CYC > (1 << tre_pkg::CNT_W)) begin
            $error("tre_encoder: SEP_CYC out of range");
        end
        if (BIT_CYC < 1 || BIT_CYC > tre_pkg::PAT_W) begin
            $error("tre_encoder: BIT_CYC out of range");
        end
        // each symbol needs its own waveform within one bit
        if (((HIGH_PAT ^ LOW_PAT) & PAT_MASK) == 16'h0000) begin
            $error("tre_encoder: high and low patterns alike");
        end
        if (((HIGH_PAT ^ OPEN_PAT) & PAT_MASK) == 16'h0000) begin
            $error("tre_encoder: high and open patterns alike");
        end
        if (((LOW_PAT ^ OPEN_PAT) & PAT_MASK) == 16'h0000) begin
            $error("tre_encoder: low and open patterns alike");
        end
        // fixed address slots exist on every variant
        if ((BONDED & tre_pkg::ADDR_FIXED_MASK) != tre_pkg::ADDR_FIXED_MASK) begin
            $error("tre_encoder: fixed address positions unbonded");
        end
        // a data variant without a bonded data pad could never send
        if (DATA_TRIGGER && (DT_BONDED == 6'h00)) begin
            $error("tre_encoder: no bonded data trigger pad");
        end
    end

    // ------------------------------------------------------------
    // constants at register widths
    // ------------------------------------------------------------
    localparam logic [tre_pkg::TICK_W-1:0] TICK_LAST  =
        tre_pkg::TICK_W'(OSC_DIV - 1);
    localparam logic [tre_pkg::CNT_W-1:0]  PILOT_LAST =
        tre_pkg::CNT_W'(PILOT_CYC - 1);
    localparam logic [tre_pkg::CNT_W-1:0]  SYNC_LAST  =
        tre_pkg::CNT_W'(SYNC_CYC - 1);
    localparam logic [tre_pkg::CNT_W-1:0]  BIT_LAST   =
        tre_pkg::CNT_W'(BIT_CYC - 1);
    localparam logic [tre_pkg::CNT_W-1:0]  SEP_LAST   =
        tre_pkg::CNT_W'(SEP_CYC - 1);
    localparam logic [tre_pkg::POS_W-1:0]  POS_LAST   =
        tre_pkg::POS_W'(tre_pkg::LAST_POS);
    localparam logic [tre_pkg::WORD_W-1:0] WORD_LAST  =
        tre_pkg::WORD_W'(tre_pkg::LAST_WORD);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [17:0]                 lvl_s1;
        logic [17:0]                 lvl_s2;
        logic [17:0]                 opn_s1;
        logic [17:0]                 opn_s2;
        logic [5:0]                  dt_s1;
        logic [5:0]                  dt_s2;
        logic                        te_s1;
        logic                        te_s2;
        tre_pkg::tre_phase_t         phase;
        logic [tre_pkg::WORD_W-1:0]  word;
        logic [tre_pkg::POS_W-1:0]   pos;
        logic [tre_pkg::CNT_W-1:0]   cyc;
        logic [tre_pkg::TICK_W-1:0]  tick;
        tre_pkg::tre_sym_t [17:0]    snap;
        logic                        osc_run;
        logic                        dout;
        logic                        led_n;
    } tre_enc_state_t;

    tre_enc_state_t r;
    tre_enc_state_t next_r;

    // ------------------------------------------------------------
    // per-position symbol resolution
    // ------------------------------------------------------------
    tre_pkg::tre_sym_t [17:0] cur_sym;

    genvar gi;
    generate
        for (gi = 0; gi < tre_pkg::NUM_POS; gi++) begin : g_pos
            if (!BONDED[gi] && DATA_TRIGGER && tre_pkg::DT_MASK[gi]) begin : g_dummy_low
                assign cur_sym[gi] = tre_pkg::SYM_LOW;
            end else if (!BONDED[gi]) begin : g_dummy_open
                assign cur_sym[gi] = tre_pkg::SYM_OPEN;
            end else if (DATA_TRIGGER && tre_pkg::DT_MASK[gi]) begin : g_data
                // pull-down pad: never open, floating reads low
                assign cur_sym[gi] = r.dt_s2[gi - tre_pkg::DT_BASE] ?
                                     tre_pkg::SYM_HIGH : tre_pkg::SYM_LOW;
            end else begin : g_trinary
                assign cur_sym[gi] = r.opn_s2[gi] ? tre_pkg::SYM_OPEN :
                                     (r.lvl_s2[gi] ? tre_pkg::SYM_HIGH :
                                      tre_pkg::SYM_LOW);
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // trigger and oscillator tick
    // ------------------------------------------------------------
    logic trig;
    logic osc_edge;
    logic bit_level;
    logic [1:0] bit_sym;

    assign trig = DATA_TRIGGER ? |(r.dt_s2 & DT_BONDED) : r.te_s2;
    assign osc_edge = r.osc_run && (r.tick == TICK_LAST);
    // pos is 0 after reset and parks at 17 after the last bit of each word; the guard keeps the index legal
    assign bit_sym = (r.pos <= POS_LAST) ? r.snap[r.pos] : tre_pkg::SYM_LOW;

    tre_bit_shaper #(
        .BIT_CYC  (BIT_CYC),
        .HIGH_PAT (HIGH_PAT),
        .LOW_PAT  (LOW_PAT),
        .OPEN_PAT (OPEN_PAT)
    ) u_shaper (
        .sym   (bit_sym),
        .phase (r.cyc),
        .level (bit_level)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;

        // pads come from outside the clock domain
        next_r.lvl_s1 = addr_or_data_inputs_level;
        next_r.lvl_s2 = r.lvl_s1;
        next_r.opn_s1 = addr_or_data_inputs_open;
        next_r.opn_s2 = r.opn_s1;
        next_r.dt_s1  = data_trigger_inputs;
        next_r.dt_s2  = r.dt_s1;
        next_r.te_s1  = send_trigger;
        next_r.te_s2  = r.te_s1;

        // oscillator model: ticks only while running
        if (r.osc_run) begin
            next_r.tick = osc_edge ? '0 : r.tick + 1'b1;
        end else begin
            next_r.tick = '0;
        end

        unique case (r.phase)
            tre_pkg::PH_IDLE: begin
                if (trig) begin
                    next_r.phase   = tre_pkg::PH_PILOT;
                    next_r.word    = '0;
                    next_r.cyc     = '0;
                    // pads frozen per word so no slot changes mid-bit
                    next_r.snap    = cur_sym;
                    next_r.osc_run = 1'b1;
                end else begin
                    next_r.osc_run = 1'b0;
                end
            end
            tre_pkg::PH_PILOT: begin
                if (osc_edge) begin
                    if (r.cyc == PILOT_LAST) begin
                        next_r.phase = tre_pkg::PH_SYNC;
                        next_r.cyc   = '0;
                    end else begin
                        next_r.cyc = r.cyc + 1'b1;
                    end
                end
            end
            tre_pkg::PH_SYNC: begin
                if (osc_edge) begin
                    if (r.cyc == SYNC_LAST) begin
                        next_r.phase = tre_pkg::PH_BITS;
                        next_r.cyc   = '0;
                        next_r.pos   = '0;
                    end else begin
                        next_r.cyc = r.cyc + 1'b1;
                    end
                end
            end
            tre_pkg::PH_BITS: begin
                if (osc_edge) begin
                    if (r.cyc == BIT_LAST) begin
                        next_r.cyc = '0;
                        // dummies still consume a slot each
                        if (r.pos == POS_LAST) begin
                            next_r.phase = tre_pkg::PH_SEP;
                        end else begin
                            next_r.pos = r.pos + 1'b1;
                        end
                    end else begin
                        next_r.cyc = r.cyc + 1'b1;
                    end
                end
            end
            tre_pkg::PH_SEP: begin
                if (osc_edge) begin
                    if (r.cyc != SEP_LAST) begin
                        next_r.cyc = r.cyc + 1'b1;
                    end else if (r.word != WORD_LAST) begin
                        // trigger is not looked at mid-cycle
                        next_r.word  = r.word + 1'b1;
                        next_r.phase = tre_pkg::PH_PILOT;
                        next_r.cyc   = '0;
                        next_r.snap  = cur_sym;
                    end else if (trig) begin
                        next_r.word  = '0;
                        next_r.phase = tre_pkg::PH_PILOT;
                        next_r.cyc   = '0;
                        next_r.snap  = cur_sym;
                    end else begin
                        next_r.phase   = tre_pkg::PH_IDLE;
                        next_r.cyc     = '0;
                        next_r.osc_run = 1'b0;
                    end
                end
            end
            default: begin
                next_r.phase   = tre_pkg::PH_IDLE;
                next_r.osc_run = 1'b0;
            end
        endcase

        // output follows the period one clock late, far below an osc cycle
        next_r.dout  = (r.phase == tre_pkg::PH_SYNC) ||
                       ((r.phase == tre_pkg::PH_BITS) && bit_level);
        // indicator sinks current, so it is lit low for the whole cycle
        next_r.led_n = !(r.phase != tre_pkg::PH_IDLE);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            r         <= '0;
            r.phase   <= tre_pkg::PH_IDLE;
            r.led_n   <= 1'b1;
            r.osc_run <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign dout    = r.dout;
    assign led_n   = r.led_n;
    assign osc_run = r.osc_run;

endmodule : tre_encoder
`default_nettype wire

/* File: src/tre_pkg.sv */
// Summary of operation
// - trigger rising starts three-word transmission cycle
// - held trigger repeats cycles back to back
// - trigger drop finishes current cycle, then stops
// - each word has four periods
// - high, low, open sent as distinct waveforms
// - scan positions 0 through 17 in order
// - unbonded sent open, data positions low
// - dummy positions keep their own slots
// - any high bonded data input triggers transmission
// - no trigger: oscillator stopped, output silent
// - fixed bit map, 0-3, 6-9 address
// - data inputs pulled low, data plus enable
package tre_pkg;

    // ------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------
    localparam int          NUM_POS         = 18;
    localparam int          WORDS_PER_CYCLE = 3;
    localparam int          NUM_DT          = 6;
    localparam int          DT_BASE         = 12;
    localparam int          LAST_POS        = NUM_POS - 1;
    localparam int          LAST_WORD       = WORDS_PER_CYCLE - 1;
    localparam logic [17:0] ADDR_FIXED_MASK = 18'h003cf;
    localparam logic [17:0] DT_MASK         = 18'h3f000;
    localparam logic [17:0] BONDED_ALL      = 18'h3ffff;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int OSC_PERIOD_NS = 10000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int OSC_DIV       = OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PILOT_CYC     = 12;
    localparam int SYNC_CYC      = 1;
    localparam int BIT_CYC       = 3;
    localparam int SEP_CYC       = 4;

    // pattern bit k is the output level in oscillator cycle k of a bit
    localparam logic [15:0] HIGH_PAT = 16'h0003;
    localparam logic [15:0] LOW_PAT  = 16'h0001;
    localparam logic [15:0] OPEN_PAT = 16'h0002;

    // ------------------------------------------------------------
    // widths and types
    // ------------------------------------------------------------
    localparam int TICK_W = 12;
    localparam int CNT_W  = 16;
    localparam int POS_W  = 5;
    localparam int WORD_W = 2;
    localparam int PAT_W  = 16;

    typedef enum logic [1:0] {
        SYM_LOW,
        SYM_HIGH,
        SYM_OPEN
    } tre_sym_t;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_PILOT,
        PH_SYNC,
        PH_BITS,
        PH_SEP
    } tre_phase_t;

endpackage : tre_pkg

/* File: src/tre_bit_shaper.sv */
`timescale 1ns/1ps
`default_nettype none
module tre_bit_shaper #(
    parameter int          BIT_CYC  = tre_pkg::BIT_CYC,
    parameter logic [15:0] HIGH_PAT = tre_pkg::HIGH_PAT,
    parameter logic [15:0] LOW_PAT  = tre_pkg::LOW_PAT,
    parameter logic [15:0] OPEN_PAT = tre_pkg::OPEN_PAT
) (
    // symbol and position within the bit
    input  wire logic [1:0]                sym,
    input  wire logic [tre_pkg::CNT_W-1:0] phase,
    // waveform level
    output logic                           level
);

    initial begin
        if (BIT_CYC < 1 || BIT_CYC > tre_pkg::PAT_W) begin
            $error("tre_bit_shaper: BIT_CYC out of range");
        end
    end

    logic [15:0] pat;
    logic [3:0]  idx;

    always_comb begin
        idx = phase[3:0];
        unique case (tre_pkg::tre_sym_t'(sym))
            tre_pkg::SYM_HIGH: pat = HIGH_PAT;
            tre_pkg::SYM_OPEN: pat = OPEN_PAT;
            default:           pat = LOW_PAT;
        endcase
        level = pat[idx];
    end

endmodule : tre_bit_shaper
`default_nettype wire

/* File: verif/tre_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module tre_checker #(
    parameter bit          DATA_TRIGGER = 1'b0,
    parameter logic [17:0] BONDED       = 18'h3ffff,
    parameter int          OSC_DIV      = 4,
    parameter int          PILOT_CYC    = 2,
    parameter int          SYNC_CYC     = 1,
    parameter int          BIT_CYC      = 3,
    parameter int          SEP_CYC      = 2
) (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // pads and triggers
    input wire logic [17:0] addr_or_data_inputs_level,
    input wire logic [17:0] addr_or_data_inputs_open,
    input wire logic        send_trigger,
    input wire logic [5:0]  data_trigger_inputs,
    // outputs
    input wire logic        dout,
    input wire logic        led_n,
    input wire logic        osc_run
);
    localparam int CYC = 3 * (PILOT_CYC + SYNC_CYC + 18 * BIT_CYC + SEP_CYC) * OSC_DIV;
    logic trig;
    int   run_cnt;
    assign trig = DATA_TRIGGER ? |(data_trigger_inputs & BONDED[17:12]) : send_trigger;
    always_ff @(posedge clock) begin
        run_cnt <= (rst || !osc_run) ? 0 : run_cnt + 1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    AST_IDLE_SILENT: assert property (
        !osc_run ##1 !osc_run |-> !dout) else $error("dout active while idle");
    AST_START_LAT: assert property (
        $rose(trig) && !osc_run |-> ##[1:3] osc_run) else $error("no start after trigger");
    AST_NO_SPURIOUS: assert property (
        $rose(osc_run) |-> $past(trig, 2) || $past(trig, 3)) else $error("start without trigger");
    AST_LED_ON: assert property (
        $rose(osc_run) |=> !led_n) else $error("led not lit after start");
    AST_LED_RUN: assert property (
        osc_run ##1 osc_run |-> !led_n) else $error("led dark while sending");
    AST_LED_IDLE: assert property (
        !osc_run ##1 !osc_run |-> led_n) else $error("led lit while idle");
    AST_PILOT_LOW: assert property (
        $rose(osc_run) |-> !dout [*4]) else $error("pilot not low");
    AST_KEEP_RUN: assert property (
        osc_run && trig && $past(trig) && $past(trig, 2) && $past(trig, 3) |=> osc_run)
        else $error("stopped with trigger held");
    AST_RUN_LEN: assert property (
        $fell(osc_run) |-> run_cnt >= CYC - 2 && (run_cnt + 2) % CYC < 5)
        else $error("cycle cut short");
endmodule : tre_checker
bind tre_encoder tre_checker #(.DATA_TRIGGER(DATA_TRIGGER), .BONDED(BONDED), .OSC_DIV(OSC_DIV),
    .PILOT_CYC(PILOT_CYC), .SYNC_CYC(SYNC_CYC), .BIT_CYC(BIT_CYC), .SEP_CYC(SEP_CYC)) u_chk (
    .clock(clock), .rst(rst), .addr_or_data_inputs_level(addr_or_data_inputs_level),
    .addr_or_data_inputs_open(addr_or_data_inputs_open), .send_trigger(send_trigger),
    .data_trigger_inputs(data_trigger_inputs), .dout(dout), .led_n(led_n), .osc_run(osc_run));
`default_nettype wire

/* File: verif/tre_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tre_rx_model #(
    parameter int OSC_DIV   = 4,
    parameter int PILOT_CYC = 2,
    parameter int SYNC_CYC  = 1,
    parameter int BIT_CYC   = 3,
    parameter int SEP_CYC   = 2
) (
    // link side
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        din,
    input  wire logic        run,
    // decoded word
    output logic [35:0]      syms,
    output logic [17:0]      data,
    output logic             word_stb,
    output logic             frame_err
);
    localparam int WL = PILOT_CYC + SYNC_CYC + 18 * BIT_CYC + SEP_CYC;
    localparam int B0 = PILOT_CYC + SYNC_CYC;
    logic [WL-1:0] smp;
    logic [15:0]   pat;
    int            k;
    int            c;
    // mid-cycle sampling tolerates a clock of skew either way
    always @(posedge clock) begin
        word_stb <= 1'b0;
        if (rst) frame_err <= 1'b0;
        if (rst || !run) begin
            k <= 0;
        end else begin
            k <= k + 1;
            c = (k / OSC_DIV) % WL;
            if (k % OSC_DIV == OSC_DIV / 2) begin
                smp[c] = din;
                if (c == WL - 1) begin
                    if ((|smp[PILOT_CYC-1:0]) || !(&smp[B0-1:PILOT_CYC])
                        || (|smp[WL-1:WL-SEP_CYC])) frame_err <= 1'b1;
                    for (int p = 0; p < 18; p++) begin
                        pat = 16'(smp[B0 + BIT_CYC * p +: BIT_CYC]);
                        data[p] <= (pat === tre_pkg::HIGH_PAT);
                        if (pat === tre_pkg::HIGH_PAT) syms[2*p +: 2] <= tre_pkg::SYM_HIGH;
                        else if (pat === tre_pkg::LOW_PAT) syms[2*p +: 2] <= tre_pkg::SYM_LOW;
                        else if (pat === tre_pkg::OPEN_PAT) syms[2*p +: 2] <= tre_pkg::SYM_OPEN;
                        else frame_err <= 1'b1;
                    end
                    word_stb <= 1'b1;
                end
            end
        end
    end
endmodule : tre_rx_model
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int          DIV     = 4;
    localparam int          PIL     = 2;
    localparam int          SEP     = 2;
    localparam int          CYC     = 3 * (PIL + 1 + 18 * 3 + SEP) * DIV;
    localparam logic [17:0] BOND_TE = 18'h0fbdf;
    localparam logic [17:0] BOND_DT = 18'h0dbcf;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        send_trigger = 1'b0;
    logic [17:0] lvl = 18'h0;
    logic [17:0] opn = 18'h0;
    logic [5:0]  dti = 6'h0;
    logic [5:0]  dti_run;
    logic [31:0] seed = 32'd28009;
    logic        dout_te, dout_dt, run_te, run_dt, led_te, led_dt, stb_te, stb_dt, fe_te, fe_dt;
    logic [35:0] sy_te, sy_dt;
    logic [17:0] dat_te, dat_dt;
    logic [1:0]  es;
    int          errors = 0, checks = 0, nwt, nwd, ncyc, h;
    always #2.5 clock = ~clock;
    // ------------------------------------------------------------
    // two variants side by side, each with its own receiver
    // ------------------------------------------------------------
    tre_encoder #(.DATA_TRIGGER(1'b0), .BONDED(BOND_TE), .OSC_DIV(DIV), .PILOT_CYC(PIL),
        .SEP_CYC(SEP)) u_dut (.clock(clock), .rst(rst), .addr_or_data_inputs_level(lvl),
        .addr_or_data_inputs_open(opn), .send_trigger(send_trigger),
        .data_trigger_inputs(dti), .dout(dout_te), .led_n(led_te), .osc_run(run_te));
    tre_encoder #(.DATA_TRIGGER(1'b1), .BONDED(BOND_DT), .OSC_DIV(DIV), .PILOT_CYC(PIL),
        .SEP_CYC(SEP)) u_dut_dt (.clock(clock), .rst(rst), .addr_or_data_inputs_level(lvl),
        .addr_or_data_inputs_open(opn), .send_trigger(send_trigger),
        .data_trigger_inputs(dti), .dout(dout_dt), .led_n(led_dt), .osc_run(run_dt));
    tre_rx_model #(.OSC_DIV(DIV), .PILOT_CYC(PIL), .SEP_CYC(SEP)) u_rx_te (.clock(clock),
        .rst(rst), .din(dout_te), .run(run_te), .syms(sy_te), .data(dat_te), .word_stb(stb_te),
        .frame_err(fe_te));
    tre_rx_model #(.OSC_DIV(DIV), .PILOT_CYC(PIL), .SEP_CYC(SEP)) u_rx_dt (.clock(clock),
        .rst(rst), .din(dout_dt), .run(run_dt), .syms(sy_dt), .data(dat_dt), .word_stb(stb_dt),
        .frame_err(fe_dt));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic [1:0] exp_sym(input bit dt, input logic [17:0] bnd, input int p,
                                          input logic [5:0] d);
        if (!bnd[p]) return (dt && p >= 12) ? tre_pkg::SYM_LOW : tre_pkg::SYM_OPEN;
        if (dt && p >= 12) return d[p-12] ? tre_pkg::SYM_HIGH : tre_pkg::SYM_LOW;
        if (opn[p]) return tre_pkg::SYM_OPEN;
        return lvl[p] ? tre_pkg::SYM_HIGH : tre_pkg::SYM_LOW;
    endfunction : exp_sym
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------
    // word checks; data pads drop to zero after the release word
    // ------------------------------------------------------------
    always @(negedge clock) begin
        if (stb_te) begin
            for (int p = 0; p < 18; p++) begin
                es = exp_sym(0, BOND_TE, p, 6'h0);
                check(sy_te[2*p +: 2], es);
                check(dat_te[p], es == tre_pkg::SYM_HIGH);
            end
            nwt++;
        end
        if (stb_dt) begin
            for (int p = 0; p < 18; p++) begin
                es = exp_sym(1, BOND_DT, p, (nwd <= 3 * (ncyc - 1)) ? dti_run : 6'h0);
                check(sy_dt[2*p +: 2], es);
                check(dat_dt[p], es == tre_pkg::SYM_HIGH);
            end
            nwd++;
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(posedge clock);
        for (int r = 0; r < 8; r++) begin
            ncyc = 1 + r % 2;
            seed = xs(seed);
            lvl <= (r == 1) ? 18'h3ffff : seed[17:0];
            seed = xs(seed);
            opn <= (r == 0) ? 18'h3ffff : (r == 1) ? 18'h0 : seed[17:0];
            dti_run = (r == 2) ? 6'h02 : ((seed[25:20] & 6'h0d) | 6'h01);
            nwt = 0;
            nwd = 0;
            @(posedge clock);
            send_trigger <= 1'b1;
            dti <= dti_run;
            seed = xs(seed);
            h = (ncyc - 1) * CYC + 60 + int'(seed % 120);
            repeat (h) @(posedge clock);
            send_trigger <= 1'b0;
            dti <= 6'h0;
            for (int i = 0; i < 2 * CYC && (run_te || run_dt); i++) @(posedge clock);
            repeat (4) @(posedge clock);
            check(36'(nwt), 36'(3 * ncyc));
            check(36'(nwd), (r == 2) ? 36'h0 : 36'(3 * ncyc));
            check({run_te, led_te, dout_te, run_dt, led_dt, dout_dt}, 36'h12);
            check({fe_te, fe_dt}, 36'h0);
        end
        // reset in mid-word must drop both variants at once, with no restart
        send_trigger <= 1'b1;
        dti <= 6'h01;
        repeat (100) @(posedge clock);
        rst <= 1'b1;
        send_trigger <= 1'b0;
        dti <= 6'h0;
        repeat (3) @(posedge clock);
        check({run_te, led_te, dout_te, run_dt, led_dt, dout_dt}, 36'h12);
        rst <= 1'b0;
        repeat (8) @(posedge clock);
        check({run_te, led_te, dout_te, run_dt, led_dt, dout_dt}, 36'h12);
        report_and_stop();
    end
    initial begin
        repeat (40000) @(posedge clock);
        errors++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
